/* core/timer_counter.sv */
// 8-bit timer/counter with private prescaler, overflow flag and interrupt.
// Assumes clk is the instruction clock, sleep comes from the processor and
// the count pin is asynchronous to clk.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

// Operation
// - Timer mode unprescaled counts every instruction cycle
// - Count write holds counting two cycles
// - Source select one counts external pin edges
// - Edge select picks rising or falling transition
// - Bypass clear inserts prescaler, set gives 1:1
// - Eight prescale ratios, 1:2 to 1:256
// - Prescaler private, separate from watchdog timer
// - Prescaler count not readable or writable
// - Count write clears the prescaler
// - Wrap FFh to 00h sets overflow flag
// - Only software clears the overflow flag
// - Interrupt forwarded only when enable bit set
// - External edge synchronised to instruction clock
// - Sleep stops counting, count kept
// - Overflow never wakes processor from sleep
// - Overflow available as gate for 16-bit timer
module timer_counter
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic sleep,
    input wire logic external_count_input,
    input wire logic [`ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic overflow_gate
);
    import tmr_pkg::*;

    bus_state_t bus_state_r;
    logic [31:0] readdata_r;
    byte_t timer_count_value_r;
    byte_t timer_count_value_nxt;
    logic [5:0] option_r;
    logic overflow_irq_enable_r;
    logic overflow_flag_r;
    logic [1:0] inhibit_r;
    logic overflow_gate_r;

    logic access;
    logic take;
    logic wr_lane0;
    logic wr_count;
    logic wr_option;
    logic wr_intctl;
    logic wr_clear;
    logic wr_enable;
    logic run;
    logic pin_edge;
    logic src_tick;
    logic pre_tick;
    logic inc;
    logic wrap;
    logic flag_clear;
    count_source_t source;
    logic edge_falling;
    logic bypass;
    rate_t rate;
    byte_t option_rd;
    byte_t intctl_rd;
    byte_t status_rd;
    byte_t enable_rd;
    byte_t rd_byte;

    // Address decode shared by the write strobes and the read mux
    function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
        input logic [`ADDR_W-1:0] off);
        return addr == off;
    endfunction

    // Places one flag at its field position in a register byte
    function automatic byte_t place_bit(input logic value, input int unsigned pos);
        byte_t b;
        b = 8'h00;
        b[pos[2:0]] = value;
        return b;
    endfunction

    // Registers are eight bits wide; the upper lanes always read zero
    function automatic logic [31:0] word_of(input byte_t b);
        return {24'h00_0000, b};
    endfunction

    assign source = option_r[`OPT_SRC_BIT] ? SRC_PIN : SRC_INSTR;
    assign edge_falling = option_r[`OPT_EDGE_BIT];
    assign bypass = option_r[`OPT_BYPASS_BIT];
    assign rate = option_r[`OPT_RATE_LSB +: 3];

    // Bus: one wait cycle on every access, writes land when waitrequest is low
    assign access = avs_read | avs_write;
    assign avs_waitrequest = access && (bus_state_r != BUS_ACK);
    assign take = avs_write && (bus_state_r == BUS_ACK) && ce;
    assign wr_lane0 = take && avs_byteenable[0];
    assign wr_count = wr_lane0 && reg_hit(avs_address, `OFF_COUNT);
    assign wr_option = wr_lane0 && reg_hit(avs_address, `OFF_OPTION);
    assign wr_intctl = wr_lane0 && reg_hit(avs_address, `OFF_INTCTL);
    assign wr_clear = wr_lane0 && reg_hit(avs_address, `OFF_CLEAR);
    assign wr_enable = wr_lane0 && reg_hit(avs_address, `OFF_ENABLE);
    assign avs_readdata = readdata_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            bus_state_r <= BUS_IDLE;
        else if (ce)
        begin
            case (bus_state_r)
                BUS_IDLE:
                    if (access)
                        bus_state_r <= BUS_ACK;
                BUS_ACK:
                    bus_state_r <= BUS_IDLE;
                default:
                    bus_state_r <= BUS_IDLE;
            endcase
        end
    end

    // Prescaler count has no address, so it can never be read back
    assign option_rd = {2'b00, option_r};
    assign intctl_rd = place_bit(overflow_irq_enable_r, `ICTL_IE_BIT)
        | place_bit(overflow_flag_r, `ICTL_IF_BIT);
    assign status_rd = place_bit(overflow_flag_r, `EVT_OVF_BIT);
    assign enable_rd = place_bit(overflow_irq_enable_r, `EVT_OVF_BIT);

    // Clear register is write-only, so it reads zero like an unmapped offset
    always_comb
    begin
        rd_byte = 8'h00;
        if (reg_hit(avs_address, `OFF_COUNT))
            rd_byte = timer_count_value_r;
        else if (reg_hit(avs_address, `OFF_OPTION))
            rd_byte = option_rd;
        else if (reg_hit(avs_address, `OFF_INTCTL))
            rd_byte = intctl_rd;
        else if (reg_hit(avs_address, `OFF_STATUS))
            rd_byte = status_rd;
        else if (reg_hit(avs_address, `OFF_ENABLE))
            rd_byte = enable_rd;
    end

    // Latched in the wait cycle, so the word stands when waitrequest drops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            readdata_r <= 32'h0000_0000;
        else if (ce)
        begin
            if (avs_read && bus_state_r == BUS_IDLE)
                readdata_r <= word_of(rd_byte);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            option_r <= `OPT_RESET;
        else if (ce && wr_option)
            option_r <= avs_writedata[5:0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overflow_irq_enable_r <= 1'b0;
        else if (ce)
        begin
            if (wr_intctl)
                overflow_irq_enable_r <= avs_writedata[`ICTL_IE_BIT];
            else if (wr_enable)
                overflow_irq_enable_r <= avs_writedata[`EVT_OVF_BIT];
        end
    end

    // Sleep freezes the increment path (count writes still load), so no overflow can arise to wake
    // the processor
    assign run = ce && !sleep;

    // Pin is resampled on the instruction clock before it can count
    edge_sync u_edge_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .pin(external_count_input),
        .falling_sel(edge_falling),
        .edge_pulse(pin_edge)
    );

    // Narrow pin pulses shorter than two clocks may be missed
    always_comb
    begin
        case (source)
            SRC_INSTR: src_tick = 1'b1;
            SRC_PIN: src_tick = pin_edge;
            default: src_tick = 1'b0;
        endcase
    end

    // Dedicated divider; the watchdog has no connection to it
    prescaler #(.WIDTH(8)) u_prescaler
    (
        .clk(clk),
        .arst_n(arst_n),
        // Only the tick sees sleep: a count write in sleep must still clear it
        .ce(ce),
        .clear(wr_count),
        .in_tick(src_tick && inhibit_r == 2'h0 && !sleep),
        .bypass(bypass),
        .rate(rate),
        .out_tick(pre_tick)
    );

    // Counting is held off while the post-write inhibit runs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            inhibit_r <= 2'h0;
        else if (ce)
        begin
            if (wr_count)
                inhibit_r <= `INHIBIT_CYCLES;
            else if (run && inhibit_r != 2'h0)
                inhibit_r <= inhibit_r - 2'h1;
        end
    end

    assign inc = run && pre_tick && (inhibit_r == 2'h0);
    assign wrap = inc && (timer_count_value_r == `COUNT_MAX);

    always_comb
    begin
        timer_count_value_nxt = timer_count_value_r;
        if (wr_count)
            timer_count_value_nxt = avs_writedata[7:0];
        else if (inc)
            timer_count_value_nxt = timer_count_value_r + 8'h01;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer_count_value_r <= `COUNT_RESET;
        else if (ce)
            timer_count_value_r <= timer_count_value_nxt;
    end

    // Clear comes only from software: a zero in the flag bit of the control
    // register or a one in the clear register
    assign flag_clear = (wr_intctl && !avs_writedata[`ICTL_IF_BIT])
        || (wr_clear && avs_writedata[`EVT_OVF_BIT]);

    // Set regardless of enable, and a wrap wins over a same-cycle clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overflow_flag_r <= 1'b0;
        else if (ce)
        begin
            if (wrap)
                overflow_flag_r <= 1'b1;
            else if (flag_clear)
                overflow_flag_r <= 1'b0;
        end
    end

    // One-cycle wrap pulse for the 16-bit timer's gate input
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overflow_gate_r <= 1'b0;
        else if (ce)
            overflow_gate_r <= wrap;
    end

    assign overflow_gate = overflow_gate_r;
    assign irq = overflow_flag_r && overflow_irq_enable_r;
endmodule

/* inc/tmr_cfg.svh */
// Register map, field positions, reset values and timing counts of the 8-bit timer/counter.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define ADDR_W 5
`define OFF_COUNT 5'h00
`define OFF_OPTION 5'h04
`define OFF_INTCTL 5'h08
`define OFF_STATUS 5'h0c
`define OFF_CLEAR 5'h10
`define OFF_ENABLE 5'h14

`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_BYPASS_BIT 3
`define OPT_RATE_LSB 0
`define OPT_RESET 6'h3f

`define ICTL_IE_BIT 5
`define ICTL_IF_BIT 2

`define EVT_OVF_BIT 0

`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hff
`define INHIBIT_CYCLES 2'h2

`endif

/* inc/tmr_pkg.sv */
// Types shared by the timer/counter design files.
// Constants live in tmr_cfg.svh.
package tmr_pkg;
    typedef enum logic {SRC_INSTR, SRC_PIN} count_source_t;
    typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;
    typedef logic [2:0] rate_t;
    typedef logic [7:0] byte_t;
endpackage

/* core/edge_sync.sv */
// Two-flop synchroniser and edge detector for the external count input.
// Assumes the pin holds each level for at least two clocks.
`timescale 1ns/1ps
module edge_sync
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic pin,
    input wire logic falling_sel,
    output logic edge_pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // The first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    always_comb
    begin
        if (falling_sel)
            edge_pulse = prev_r & ~sync_r;
        else
            edge_pulse = ~prev_r & sync_r;
    end
endmodule

/* core/prescaler.sv */
// Private prescaler of the timer: divides source ticks by 2 to 256.
// Its count is not visible to software; the timer clears it on a count write.
`timescale 1ns/1ps
module prescaler
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic in_tick,
    input wire logic bypass,
    input wire tmr_pkg::rate_t rate,
    output logic out_tick
);
    import tmr_pkg::*;

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] mask;

    // Ratio 2^(n+1): the tick fires when the low n+1 bits are all ones
    function automatic logic [WIDTH-1:0] rate_mask(input rate_t r);
        logic [WIDTH:0] full;
        full = ({{WIDTH{1'b0}}, 1'b1} << (r + 4'h1)) - 1'b1;
        return full[WIDTH-1:0];
    endfunction

    assign mask = rate_mask(rate);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_r <= '0;
        else if (ce)
        begin
            if (clear)
                cnt_r <= '0;
            else if (in_tick && !bypass)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    always_comb
    begin
        if (bypass)
            out_tick = in_tick;
        else
            out_tick = in_tick && ((cnt_r & mask) == mask);
    end
endmodule

/* verif/tmr_chk.sv */
// Port assertions for the timer/counter.
// Assumes the bind below and the map of tmr_cfg.svh.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_chk
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic sleep,
    input wire logic external_count_input,
    input wire logic [`ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic overflow_gate
);
    logic wr_ok;
    logic [5:0] opt_r;
    assign wr_ok = ce && avs_write && !avs_waitrequest && avs_byteenable[0];
    // Mode shadow, so the load check only arms in plain timer mode
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            opt_r <= `OPT_RESET;
        else if (wr_ok && avs_address == `OFF_OPTION)
            opt_r <= avs_writedata[5:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence load_max;
        wr_ok && avs_address == `OFF_COUNT && avs_writedata[7:0] == `COUNT_MAX
            && !opt_r[`OPT_SRC_BIT] && opt_r[`OPT_BYPASS_BIT];
    endsequence
    sequence run_three;
        (ce && !sleep && !avs_write)[*3];
    endsequence
    load_hold_a: assert property (load_max ##1 run_three |=> overflow_gate)
        else $error("count load not held two cycles");
    gate_pulse_a: assert property (overflow_gate |=> !overflow_gate)
        else $error("gate pulse too long");
    sleep_gate_a: assert property (sleep[*3] |-> !overflow_gate)
        else $error("wrap during sleep");
    sleep_irq_a: assert property ((sleep && !avs_write)[*3] |-> !$rose(irq))
        else $error("irq rose in sleep");
    irq_hold_a: assert property (irq && !avs_write |=> irq)
        else $error("irq dropped without write");
    irq_cause_a: assert property ($rose(irq) && !$past(avs_write) |-> ##[0:1] overflow_gate)
        else $error("irq without wrap");
    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce
        |=> !avs_waitrequest || !ce)
        else $error("more than one wait");
    rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule
bind timer_counter tmr_chk i_tmr_chk (.clk(clk), .arst_n(arst_n), .ce(ce), .sleep(sleep),
    .external_count_input(external_count_input), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .overflow_gate(overflow_gate));

/* verif/pin_src.sv */
// External clock source on the count pin.
// Assumes half is at least 2; the level stands still while run is low.
`timescale 1ns/1ps
module pin_src
(
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    logic [3:0] cnt_r = 4'h0;
    logic level_r = 1'b0;
    assign pin = level_r;
    // Each level lasts half clocks, enough for the synchroniser
    always @(posedge clk)
    begin
        if (run && cnt_r + 4'h1 >= half)
        begin
            level_r <= ~level_r;
            cnt_r <= 4'h0;
        end
        else if (run)
            cnt_r <= cnt_r + 4'h1;
    end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the timer/counter over Avalon-MM.
// Assumes the checker bind and the pin source model.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sleep = 1'b0;
    logic run = 1'b0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic pin, wait_req, irq, gate;
    logic ce = 1'b1;
    int gates = 0;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [4:0] ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h18};
    logic [7:0] re [6] = '{8'h00, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] po [5] = '{8'h28, 8'h28, 8'h38, 8'h38, 8'h28};
    logic [7:0] px [5] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h0a};
    int rn [5] = '{3, 3, 3, 3, 60};
    always #20 clk = ~clk;
    timer_counter i_timer_counter (.clk(clk), .arst_n(arst_n), .ce(ce), .sleep(sleep),
        .external_count_input(pin), .avs_address(addr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .irq(irq), .overflow_gate(gate));
    pin_src i_pin_src (.clk(clk), .run(run), .half(4'h3), .pin(pin));
    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until a rising edge samples waitrequest low; data taken there
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
        output logic [31:0] q);
        logic lo;
        @(posedge clk);
        addr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdata <= {24'h0, d};
        do
        begin
            @(posedge clk);
            lo = (wait_req === 1'b0);
            q = rdata;
        end
        while (!lo);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check($sformatf("reg %h", a), q, {24'h0, e});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic irq_is(input logic e);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask
    // Pulses of the gate output, counted at the edge that samples them
    always @(posedge clk)
    begin
        if (gate === 1'b1)
            gates++;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            final_report();
        end
    end
    initial
    begin
        int r;
        wt(5);
        arst_n <= 1'b1;
        foreach (ra[i])
            rd(ra[i], re[i]);
        wr(`OFF_OPTION, 8'h08);
        wr(`OFF_COUNT, 8'h10);
        rd(`OFF_COUNT, 8'h10);
        rd(`OFF_COUNT, 8'h12);
        for (int n = 0; n < 8; n++)
        begin
            r = 2 << n;
            wr(`OFF_OPTION, 8'(n));
            wr(`OFF_COUNT, 8'h00);
            wt(4 * r + r / 2 + 1);
            rd(`OFF_COUNT, 8'h04);
        end
        wr(`OFF_OPTION, 8'h08);
        wr(`OFF_COUNT, 8'hff);
        wt(4);
        rd(`OFF_STATUS, 8'h01);
        check("gate pulses", gates, 1);
        irq_is(1'b0);
        wr(`OFF_ENABLE, 8'h01);
        irq_is(1'b1);
        wr(`OFF_CLEAR, 8'h01);
        irq_is(1'b0);
        rd(`OFF_CLEAR, 8'h00);
        wt(300);
        irq_is(1'b1);
        check("gate pulses", gates, 2);
        rd(`OFF_INTCTL, 8'h24);
        wr(`OFF_INTCTL, 8'h00);
        irq_is(1'b0);
        rd(`OFF_STATUS, 8'h00);
        sleep <= 1'b1;
        wr(`OFF_COUNT, 8'h50);
        wt(20);
        rd(`OFF_COUNT, 8'h50);
        sleep <= 1'b0;
        wr(`OFF_COUNT, 8'h30);
        ce <= 1'b0;
        wt(20);
        ce <= 1'b1;
        rd(`OFF_COUNT, 8'h30);
        for (int i = 0; i < 5; i++)
        begin
            wr(`OFF_OPTION, po[i]);
            wr(`OFF_COUNT, 8'h00);
            wt(4);
            run <= 1'b1;
            wt(rn[i]);
            run <= 1'b0;
            wt(8);
            rd(`OFF_COUNT, px[i]);
        end
        final_report();
    end
endmodule
